// ### logic/dpram_host_cfg.svh
// timing and address constants for the dual-port ram host port controller
`ifndef DPRAM_HOST_CFG_SVH
`define DPRAM_HOST_CFG_SVH
`define CLK_PERIOD_NS 25
`define WRITE_PULSE_MIN_NS 40
`define WRITE_TO_Z_NS 30
`define DATA_SETUP_TO_WRITE_END_NS 20
`define WRITE_HOLD_AFTER_CONTENTION_NS 20
`define READ_ACCESS_NS 55
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_PLAIN_CYC 4'(`CYC_UP(`WRITE_PULSE_MIN_NS))
`define WP_OE_CYC 4'(`CYC_UP(`WRITE_TO_Z_NS + `DATA_SETUP_TO_WRITE_END_NS))
`define WH_CYC 4'(`CYC_UP(`WRITE_HOLD_AFTER_CONTENTION_NS))
`define RD_CYC 4'(`CYC_UP(`READ_ACCESS_NS))
`define MAILBOX_TOP 10'h3ff
`define MAILBOX_NEXT 10'h3fe
`endif

// ### logic/dpram_host_pkg.sv
// types shared by the dual-port ram host port controller
package dpram_host_pkg;
  typedef struct packed {
    logic write;
    logic [9:0] addr;
    logic [7:0] data;
  } req_t;
  typedef struct packed {
    logic sel_n;
    logic rw;
    logic oe_n;
    logic [9:0] addr;
  } pins_t;
endpackage : dpram_host_pkg

// ### logic/dpram_host.sv
// host-side port controller for one port of a dual-port static ram
`timescale 1ns/1ps
`default_nettype none
`include "dpram_host_cfg.svh"
module dpram_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // user request side
  input wire logic req_valid_i,
  input var dpram_host_pkg::req_t req_i,
  input wire logic oe_during_write_i,
  output logic req_ready_o,
  output logic rdata_valid_o,
  output logic [7:0] rdata_o,
  output logic busy_seen_o,
  output logic mailbox_o,
  // ram port pins
  output var dpram_host_pkg::pins_t pins_o,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  input wire logic busy_n_i,
  input wire logic int_n_i
);
  // transfer sequencing
  typedef enum {IDLE, ADDR, WPULSE, WHOLD, RACC, DONE} state_t;

  // sequencer state
  state_t state_q;
  state_t state_d;

  // request held for the whole transfer
  dpram_host_pkg::req_t cur_q;
  logic oe_w_q;

  // one down-counter serves pulse, hold and access waits
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // current write was stalled by contention
  logic blocked_q;
  logic blocked_d;

  // state decode
  wire logic in_idle = (state_q == IDLE);
  wire logic in_addr = (state_q == ADDR);
  wire logic in_pulse = (state_q == WPULSE);
  wire logic in_hold = (state_q == WHOLD);
  wire logic in_read = (state_q == RACC);
  wire logic cnt_done = (cnt_q == 4'h0);

  // contention input, active low on the pin
  wire logic busy_now = !busy_n_i;

  // ready is a flop, so a request in the first cycle after reset waits
  wire logic start = in_idle && req_valid_i && req_ready_o;

  // contention seen while the strobe is low freezes the write
  // limitation: contention that never ends stalls the port, no timeout
  wire logic stall_write = busy_now && (in_pulse || in_hold);

  // output enable low during a write needs the longer pulse
  wire logic [3:0] wp_oe_len = (`WP_OE_CYC > `WP_PLAIN_CYC) ? `WP_OE_CYC : `WP_PLAIN_CYC;
  wire logic [3:0] wp_len = oe_w_q ? wp_oe_len : `WP_PLAIN_CYC;
  wire logic [3:0] first_len = cur_q.write ? wp_len : `RD_CYC;
  wire logic [3:0] hold_len = `WH_CYC;
  wire logic read_last = in_read && cnt_done;

  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (start) begin
          state_d = ADDR;
        end
      end
      ADDR: begin
        state_d = cur_q.write ? WPULSE : RACC;
      end
      WPULSE: begin
        if (busy_now) begin
          state_d = WPULSE;
        end else if (blocked_q) begin
          // released: keep the strobe low a little longer
          state_d = WHOLD;
        end else if (cnt_done) begin
          state_d = DONE;
        end
      end
      WHOLD: begin
        if (busy_now) begin
          state_d = WPULSE;
        end else if (cnt_done) begin
          state_d = DONE;
        end
      end
      RACC: begin
        if (cnt_done) begin
          state_d = DONE;
        end
      end
      DONE: begin
        state_d = IDLE;
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    blocked_d = blocked_q;
    if (in_addr) begin
      cnt_d = first_len - 4'h1;
      blocked_d = 1'b0;
    end else if (stall_write) begin
      // reload on every stalled cycle so the hold counts from release
      cnt_d = hold_len - 4'h1;
      blocked_d = 1'b1;
    end else if (!cnt_done) begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= IDLE;
      cnt_q <= 4'h0;
      blocked_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      blocked_q <= blocked_d;
    end
  end

  // request capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q <= '0;
      oe_w_q <= 1'b0;
    end else if (start) begin
      cur_q <= req_i;
      oe_w_q <= oe_during_write_i;
    end
  end

  // next pin levels
  wire logic strobe_next = (state_d == WPULSE) || (state_d == WHOLD);
  // select falls with the strobe, never before it, so the ram keeps its
  // data pins floating while we drive them
  wire logic select_next = strobe_next || (state_d == RACC);
  wire logic read_oe_next = (state_d == RACC);
  wire logic write_oe_next = oe_w_q && strobe_next;
  // address moves only at the take edge, with the strobe still high
  wire logic [9:0] addr_next = start ? req_i.addr : pins_o.addr;
  wire logic [7:0] wdata_next = cur_q.data;
  dpram_host_pkg::pins_t pins_next;
  assign pins_next = '{sel_n: !select_next, rw: !strobe_next,
                       oe_n: !(read_oe_next || write_oe_next), addr: addr_next};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '{sel_n: 1'b1, rw: 1'b1, oe_n: 1'b1, addr: 10'h000};
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      pins_o <= pins_next;
      data_o <= wdata_next;
      data_oe_o <= strobe_next;
    end
  end

  // user side next values
  wire logic ready_next = (state_d == IDLE);
  wire logic [7:0] rdata_next = read_last ? data_i : rdata_o;
  wire logic busy_seen_next = busy_now;
  wire logic mailbox_next = !int_n_i;

  // rdata_o holds the last byte read until the next read ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      req_ready_o <= ready_next;
      rdata_valid_o <= read_last;
      rdata_o <= rdata_next;
    end
  end

  // status copies only; the ram keeps the real flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_seen_o <= 1'b0;
      mailbox_o <= 1'b0;
    end else begin
      busy_seen_o <= busy_seen_next;
      mailbox_o <= mailbox_next;
    end
  end
endmodule : dpram_host
`default_nettype wire

// ### sim/dpram_host_chk.sv
// pin assertions for the host port controller
`timescale 1ns/1ps
`default_nettype none
module dpram_host_chk (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input var dpram_host_pkg::pins_t pins_o,
  input wire logic busy_n_i,
  input wire logic data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_pulse;
    !pins_o.rw [*2];
  endsequence
  sequence strobe_fall;
    $fell(pins_o.rw);
  endsequence
  sequence sel_with_strobe;
    !pins_o.sel_n && $fell(pins_o.sel_n);
  endsequence
  chk_addr_level: assert property (
    !$stable(pins_o.addr) |-> pins_o.rw && $past(pins_o.rw)) else $error("addr moved in write");
  chk_pulse_width: assert property (strobe_fall |-> wr_pulse)
    else $error("write pulse short");
  chk_busy_hold: assert property ($rose(busy_n_i) && !pins_o.rw |=> !pins_o.rw)
    else $error("strobe released early");
  chk_sel_strobe: assert property (strobe_fall |-> sel_with_strobe)
    else $error("select fell before strobe");
  chk_drive_strobe: assert property (data_oe_o == !pins_o.rw)
    else $error("data driven outside strobe");
endmodule : dpram_host_chk
bind dpram_host dpram_host_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .pins_o(pins_o),
  .busy_n_i(busy_n_i), .data_oe_o(data_oe_o));
`default_nettype wire

// ### sim/dpram_model.sv
// one-port view of the ram
`timescale 1ns/1ps
`default_nettype none
`include "dpram_host_cfg.svh"
module dpram_model (
  // host side
  input var dpram_host_pkg::pins_t pins_i,
  input wire logic [7:0] wd_i,
  input wire logic busy_n_i,
  input wire logic set_i,
  // answers
  output logic [7:0] rd_o,
  output logic int_n_o
);
  logic [7:0] mem [1024];
  logic [7:0] last = 8'h00;
  logic flag_n = 1'b1;
  // busy_n_i is the loser's flag from the arbitrating part
  wire logic wen = !pins_i.sel_n && !pins_i.rw && busy_n_i;
  wire logic ren = !pins_i.sel_n && !pins_i.oe_n && pins_i.rw;
  assign int_n_o = flag_n;
  always @* if (wen) mem[pins_i.addr] = wd_i;
  always @* if (ren) last = mem[pins_i.addr];
  // released bus shows inverse, never a stale copy
  assign rd_o = ren ? last : ~last;
  // this port is the right one: far write of top sets, our read of top clears
  always @(posedge set_i or posedge ren) begin
    if (set_i) flag_n = 1'b0;
    else if (pins_i.addr == `MAILBOX_TOP) flag_n = 1'b1;
  end
endmodule : dpram_model
`default_nettype wire

// ### sim/dual_port_ram_write_arbitration_tb_top.sv
// random and corner tests of the host port controller
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_write_arbitration_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, vld = 1'b0, oe = 1'b0, bsy_n = 1'b1, set = 1'b0;
  dpram_host_pkg::req_t rq = '0;
  dpram_host_pkg::pins_t pins;
  logic [7:0] di, dq, rdata, ram [1024];
  logic rdy, rv, bseen, mbox, int_n;
  int errors = 0, comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  dpram_host i_dpram_host (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(vld), .req_i(rq),
    .oe_during_write_i(oe), .req_ready_o(rdy), .rdata_valid_o(rv), .rdata_o(rdata),
    .busy_seen_o(bseen), .mailbox_o(mbox), .pins_o(pins), .data_i(di), .data_o(dq),
    .data_oe_o(), .busy_n_i(bsy_n), .int_n_i(int_n));
  dpram_model i_dpram_model (.pins_i(pins), .wd_i(dq), .busy_n_i(bsy_n), .set_i(set),
    .rd_o(di), .int_n_o(int_n));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic check_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_flag
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic req(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    while (rdy !== 1'b1 && n < 50) begin
      n++;
      @(negedge clk_i);
    end
    if (rdy !== 1'b1) errors++;
    @(posedge clk_i);
    vld <= 1'b1;
    rq <= '{write: w, addr: a, data: d};
    @(posedge clk_i);
    vld <= 1'b0;
    if (!w) begin
      n = 0;
      @(negedge clk_i);
      while (rv !== 1'b1 && n < 99) begin
        n++;
        @(negedge clk_i);
      end
      if (rv !== 1'b1) errors++;
      @(posedge clk_i);
    end
    if (w) ram[a] = d;
  endtask : req
  initial begin
    logic [9:0] a;
    void'($urandom(51441));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      a = (i == 0) ? 10'h3ff : 10'($urandom);
      oe <= i[0];
      req(1'b1, a, 8'($urandom));
      req(1'b0, a, 8'h00);
      check(rdata, ram[a]);
    end
    // contention from the arbiter held from before the strobe falls
    bsy_n <= 1'b0;
    req(1'b1, a, 8'h5a);
    repeat (3) @(posedge clk_i);
    check_flag(bseen, 1'b1);
    bsy_n <= 1'b1;
    req(1'b0, a, 8'h00);
    check(rdata, 8'h5a);
    check_flag(mbox, 1'b0);
    set <= 1'b1;
    @(posedge clk_i);
    set <= 1'b0;
    repeat (3) @(posedge clk_i);
    check_flag(mbox, 1'b1);
    req(1'b0, 10'h3ff, 8'h00);
    repeat (3) @(posedge clk_i);
    check_flag(mbox, 1'b0);
    final_report();
  end
  initial begin
    #(25 * 5000);
    errors++;
    final_report();
  end
endmodule : dual_port_ram_write_arbitration_tb_top
`default_nettype wire
